// ### gosm_top.sv
// Output source selector for two general-purpose pins, with APB registers.
// Assumes status inputs from the link side are asynchronous to pclk.
`timescale 1ns/1ps
`include "gosm_cfg.svh"

// What this block does
// - Source field picks receive, status or transmit
// - Register-value mode drives the output-value bit
// - Driver enabled only when enable bit set
// - Receive codes 000 to 011 give remote pins
// - Receive codes 100/101 give lock and pass
// - Receive codes 110/111 give frame, line valid
// - Transmit codes 000/001 AND/OR selected pass
// - Transmit code 011 high during video line
// - Transmit code 100 gives multi-port synchronized
// - Transmit code 101 gives interrupt; 111 reserved
// - Second pin register at 0x11, resets zero
// - Status codes: value, lock OR/AND, pass, sync
// - First pin register at 0x10, resets zero
module gosm_top
   import gosm_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [`GOSM_ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire gosm_rx_t [3:0]    rx_status,
   input  wire gosm_tx_t [1:0]    tx_status,
   input  wire logic              frame_sync,
   output logic [1:0]             pin_out,
   output logic [1:0]             pin_oe_n
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      gosm_ctl_t [1:0] pin_ctl;
      gosm_cfg_t       cfg;
      logic [31:0]     rdata;
      logic            ready;
      logic            err;
   } gosm_top_st_t;

   gosm_top_st_t st_r;
   gosm_top_st_t st_nxt;

   localparam int RX_W  = $bits(gosm_rx_t) * 4;
   localparam int TX_W  = $bits(gosm_tx_t) * 2;
   localparam int SIG_W = RX_W + TX_W + 1;

   logic [SIG_W-1:0] raw_sig;
   logic [SIG_W-1:0] sync_sig;
   gosm_rx_t [3:0]   rx_s;
   gosm_tx_t [1:0]   tx_s;
   logic             fsync_s;
   logic [1:0]       pin_q;
   logic [1:0]       oe_n_q;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Every link-side level is filtered; skew between bits of one
   // port is accepted since each bit is a slow status level
   assign raw_sig = {rx_status, tx_status, frame_sync};

   for (genvar g = 0; g < SIG_W; g++) begin : g_sync
      gosm_sync u_sync (
         .pclk    (pclk),
         .presetn (presetn),
         .din     (raw_sig[g]),
         .dout    (sync_sig[g])
      );
   end

   assign {rx_s, tx_s, fsync_s} = sync_sig;

   // ----------------------------------------
   // Pin selectors
   // ----------------------------------------
   for (genvar p = 0; p < 2; p++) begin : g_pin
      gosm_pin_mux u_mux (
         .pclk       (pclk),
         .presetn    (presetn),
         .ctl        (st_r.pin_ctl[p]),
         .cfg        (st_r.cfg),
         .rx         (rx_s),
         .tx         (tx_s),
         .frame_sync (fsync_s),
         .pin_out    (pin_q[p]),
         .pin_oe_n   (oe_n_q[p])
      );
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   logic [`GOSM_ADDR_W-1:0] idx;
   logic                    access;
   logic                    hit;
   logic [31:0]             rd_word;

   assign idx    = paddr >> `GOSM_BYTE_SHIFT;
   assign access = psel && penable && !st_r.ready;

   // Read mux; the status word shows the pins' own driven state
   always_comb begin
      rd_word = '0;
      hit     = 1'b1;
      case (idx)
         `GOSM_ADDR_W'(`GOSM_IDX_PIN0_CTL): rd_word[7:0] = st_r.pin_ctl[0];
         `GOSM_ADDR_W'(`GOSM_IDX_PIN1_CTL): rd_word[7:0] = st_r.pin_ctl[1];
         `GOSM_ADDR_W'(`GOSM_IDX_PORT_CFG): rd_word[11:0] = st_r.cfg;
         `GOSM_ADDR_W'(`GOSM_IDX_PIN_STS):  rd_word[3:0] = {oe_n_q, pin_q};
         default:                           hit = 1'b0;
      endcase
   end

   // One wait state: answer one cycle after the access phase starts,
   // so a read returns the value registered at that edge
   always_comb begin
      st_nxt       = st_r;
      st_nxt.ready = access;
      st_nxt.err   = access && !hit;
      if (access) begin
         st_nxt.rdata = (!pwrite && hit) ? rd_word : '0;
      end
      if (access && pwrite && pstrb[0]) begin
         case (idx)
            `GOSM_ADDR_W'(`GOSM_IDX_PIN0_CTL):
               st_nxt.pin_ctl[0] = pwdata[7:0];
            `GOSM_ADDR_W'(`GOSM_IDX_PIN1_CTL):
               st_nxt.pin_ctl[1] = pwdata[7:0];
            `GOSM_ADDR_W'(`GOSM_IDX_PORT_CFG):
               st_nxt.cfg[7:0] = pwdata[7:0];
            default: ;
         endcase
      end
      if (access && pwrite && pstrb[1] && idx == `GOSM_ADDR_W'(`GOSM_IDX_PORT_CFG)) begin
         st_nxt.cfg[11:8] = pwdata[11:8];
      end
   end

   // Reset leaves both pins with drivers off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.pin_ctl[0] <= `GOSM_PIN_CTL_RST;
         st_r.pin_ctl[1] <= `GOSM_PIN_CTL_RST;
         st_r.cfg        <= `GOSM_PORT_CFG_RST;                    // All ports enabled and mapped
         st_r.rdata      <= '0;
         st_r.ready      <= 1'b0;
         st_r.err        <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata   = st_r.rdata;
   assign pready   = st_r.ready;
   assign pslverr  = st_r.err;
   assign pin_out  = pin_q;
   assign pin_oe_n = oe_n_q;

endmodule

// ### gosm_cfg.svh
// Register map, field positions and reset values of the pin output selector.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GOSM_CFG_SVH
`define GOSM_CFG_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define GOSM_IDX_PIN0_CTL   8'h10
`define GOSM_IDX_PIN1_CTL   8'h11
`define GOSM_IDX_PORT_CFG   8'h20
`define GOSM_IDX_PIN_STS    8'h21
`define GOSM_ADDR_W         10
`define GOSM_BYTE_SHIFT     2

// ----------------------------------------
// Field layout of a pin control register
// ----------------------------------------
`define GOSM_SEL_HI         7
`define GOSM_SEL_LO         5
`define GOSM_SRC_HI         4
`define GOSM_SRC_LO         2
`define GOSM_VAL_BIT        1
`define GOSM_EN_BIT         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GOSM_PIN_CTL_RST    8'h00
`define GOSM_PORT_CFG_RST   12'hfff

// ----------------------------------------
// Source codes
// ----------------------------------------
`define GOSM_SRC_RX_MAX     3'h3
`define GOSM_SRC_DEV        3'h4
`define GOSM_SRC_RSVD       3'h5
`define GOSM_SRC_TX0        3'h6
`define GOSM_SRC_TX1        3'h7

// ----------------------------------------
// Signal select codes
// ----------------------------------------
`define GOSM_SEL_0          3'h0
`define GOSM_SEL_1          3'h1
`define GOSM_SEL_2          3'h2
`define GOSM_SEL_3          3'h3
`define GOSM_SEL_4          3'h4
`define GOSM_SEL_5          3'h5
`define GOSM_SEL_6          3'h6
`define GOSM_SEL_7          3'h7

`endif

// ### gosm_pkg.sv
// Types shared by the pin output selector modules.
// Assumes gosm_cfg.svh is on the include path.
package gosm_pkg;
`include "gosm_cfg.svh"

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   // Status of one receive port
   typedef struct packed {
      logic [3:0] remote_pin;
      logic       lock;
      logic       pass;
      logic       frame_valid;
      logic       line_valid;
   } gosm_rx_t;

   // Status of one transmit port
   typedef struct packed {
      logic       frame_valid;
      logic       line_valid;
      logic       synced;
      logic       irq;
   } gosm_tx_t;

   // Pin control register fields
   typedef struct packed {
      logic [2:0] signal_select;
      logic [2:0] source_select;
      logic       output_value;
      logic       output_enable;
   } gosm_ctl_t;

   // Port configuration: enabled receive ports and transmit port membership
   typedef struct packed {
      logic [3:0] rx_enable;
      logic [3:0] tx_rx_map0;
      logic [3:0] tx_rx_map1;
   } gosm_cfg_t;

   // Synchroniser state of one input
   typedef struct packed {
      logic [2:0] stage;
      logic       level;
   } gosm_sync_t;

   // Pin driver state
   typedef struct packed {
      logic data;
      logic oe_n;
   } gosm_pin_t;

endpackage

// ### gosm_sync.sv
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ps
module gosm_sync
   import gosm_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);

   gosm_sync_t st_r;
   gosm_sync_t st_nxt;

   // Stage 0 feeds only stage 1; change taken when stages 1 and 2 agree
   always_comb begin
      st_nxt       = st_r;
      st_nxt.stage = {st_r.stage[1:0], din};
      if (st_r.stage[1] == st_r.stage[2]) begin
         st_nxt.level = st_r.stage[2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.level;

endmodule

// ### gosm_pin_mux.sv
// Source and signal selection for one output pin.
// Assumes all status inputs are already in the pclk domain.
`timescale 1ns/1ps
`include "gosm_cfg.svh"
module gosm_pin_mux
   import gosm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire gosm_ctl_t   ctl,
   input  wire gosm_cfg_t   cfg,
   input  wire gosm_rx_t [3:0] rx,
   input  wire gosm_tx_t [1:0] tx,
   input  wire logic        frame_sync,
   output logic             pin_out,
   output logic             pin_oe_n
);

   gosm_pin_t st_r;
   gosm_pin_t st_nxt;
   gosm_rx_t  rx_sel;
   gosm_tx_t  tx_sel;
   logic [3:0] lock_v;
   logic [3:0] pass_v;
   logic [3:0] en_lock;
   logic [3:0] en_pass;
   logic [3:0] tx_map;

   // Gather per-port lock and pass into vectors
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lock_v[i] = rx[i].lock;
         pass_v[i] = rx[i].pass;
      end
   end

   // Disabled ports count as neutral: one for AND, zero for OR
   assign en_lock = lock_v | ~cfg.rx_enable;
   assign en_pass = pass_v | ~cfg.rx_enable;
   assign rx_sel  = rx[ctl.source_select[1:0]];
   assign tx_sel  = tx[ctl.source_select[0]];
   assign tx_map  = ctl.source_select[0] ? cfg.tx_rx_map1 : cfg.tx_rx_map0;

   // Pick the pin level; reserved codes drive low
   always_comb begin
      st_nxt      = st_r;
      st_nxt.oe_n = ~ctl.output_enable;
      st_nxt.data = 1'b0;
      if (ctl.source_select <= `GOSM_SRC_RX_MAX) begin
         case (ctl.signal_select)
            `GOSM_SEL_0: st_nxt.data = rx_sel.remote_pin[0];
            `GOSM_SEL_1: st_nxt.data = rx_sel.remote_pin[1];
            `GOSM_SEL_2: st_nxt.data = rx_sel.remote_pin[2];
            `GOSM_SEL_3: st_nxt.data = rx_sel.remote_pin[3];
            `GOSM_SEL_4: st_nxt.data = rx_sel.lock;
            `GOSM_SEL_5: st_nxt.data = rx_sel.pass;
            `GOSM_SEL_6: st_nxt.data = rx_sel.frame_valid;
            `GOSM_SEL_7: st_nxt.data = rx_sel.line_valid;
            default:     st_nxt.data = 1'b0;
         endcase
      end else if (ctl.source_select == `GOSM_SRC_DEV) begin
         case (ctl.signal_select)
            `GOSM_SEL_0: st_nxt.data = ctl.output_value;
            `GOSM_SEL_1: st_nxt.data = |(lock_v & cfg.rx_enable);
            `GOSM_SEL_2: st_nxt.data = &en_lock;
            `GOSM_SEL_3: st_nxt.data = &en_pass;
            `GOSM_SEL_4: st_nxt.data = frame_sync;
            default:     st_nxt.data = 1'b0;
         endcase
      end else if (ctl.source_select != `GOSM_SRC_RSVD) begin
         case (ctl.signal_select)
            `GOSM_SEL_0: st_nxt.data = &(pass_v | ~tx_map);
            `GOSM_SEL_1: st_nxt.data = |(pass_v & tx_map);
            `GOSM_SEL_2: st_nxt.data = tx_sel.frame_valid;
            `GOSM_SEL_3: st_nxt.data = tx_sel.line_valid;
            `GOSM_SEL_4: st_nxt.data = tx_sel.synced;
            `GOSM_SEL_5: st_nxt.data = tx_sel.irq;
            default:     st_nxt.data = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{data: 1'b0, oe_n: 1'b1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_out  = st_r.data;
   assign pin_oe_n = st_r.oe_n;

endmodule

// ### gosm_chk.sv
// Port checker for the pin output selector.
// Assumes it is bound to gosm_top and sees only its ports.
`timescale 1ns/1ps
module gosm_chk
   import gosm_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [9:0]     paddr,
   input  wire logic [31:0]    pwdata,
   input  wire logic [3:0]     pstrb,
   input  wire logic [31:0]    prdata,
   input  wire logic           pready,
   input  wire logic           pslverr,
   input  wire gosm_rx_t [3:0] rx_status,
   input  wire gosm_tx_t [1:0] tx_status,
   input  wire logic           frame_sync,
   input  wire logic [1:0]     pin_out,
   input  wire logic [1:0]     pin_oe_n
);
   // ----------------------------------------
   // Shadow of the control bytes
   // ----------------------------------------
   logic [7:0] idx;
   logic       bad;
   logic [7:0] c0_r;
   logic [7:0] c1_r;
   assign idx = paddr[9:2];
   assign bad = !(idx inside {8'h10, 8'h11, 8'h20, 8'h21});
   // Updated only where a write really lands, so pins can be judged a cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c0_r <= 8'h00;
         c1_r <= 8'h00;
      end else if (psel & penable & pready & pwrite & pstrb[0] & ~bad) begin
         if (idx == 8'h10) c0_r <= pwdata[7:0];
         if (idx == 8'h11) c1_r <= pwdata[7:0];
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   chk_err_decode: assert property (pready |-> pslverr == bad)
      else $error("pslverr wrong");
   chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("error read not zero");
   chk_read_ctl: assert property (pready && !pwrite && idx == 8'h10 |-> prdata == {24'h0, c0_r})
      else $error("pin0 control readback wrong");
   // The shadow lags the control register by one cycle, as the pin flops do
   chk_oe_follow: assert property (pin_oe_n == ~{c1_r[0], c0_r[0]})
      else $error("output enable wrong");
   chk_value_mode: assert property (c0_r[7:2] == 6'h04 |-> pin_out[0] == c0_r[1])
      else $error("register value not driven");
   chk_rsvd_src: assert property (c1_r[4:2] == 3'h5 |-> pin_out[1] == 1'h0)
      else $error("reserved source not low");
   chk_rsvd_sel: assert property ((c0_r[4:2] == 3'h4 && c0_r[7:5] > 3'h4) ||
      c0_r[7:3] == 5'h1f |-> pin_out[0] == 1'h0)
      else $error("reserved select not low");
endmodule

bind gosm_top gosm_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .prdata, .pready, .pslverr, .rx_status, .tx_status, .frame_sync, .pin_out, .pin_oe_n);

// ### gosm_board.sv
// Board logic that samples the two pins.
// Assumes no pull resistor on either pin.
`timescale 1ns/1ps
module gosm_board (
   input  wire logic       pclk,
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe_n,
   output logic [1:0]      level
);
   // ----------------------------------------
   // Pin level
   // ----------------------------------------
   logic [1:0] last_r = 2'h0;
   // A floating pin shows the inverse of its last level, so stale data never matches
   assign level = (~pin_oe_n & pin_out) | (pin_oe_n & ~last_r);
   always_ff @(posedge pclk) last_r <= level;
endmodule

// ### gpio_output_source_mux_test.sv
// Testbench of the pin output selector: registers and full source sweep.
// Assumes gosm_pkg, gosm_top, gosm_chk and gosm_board are compiled before it.
`timescale 1ns/1ps
module gpio_output_source_mux_test;
   import gosm_pkg::*;
   logic        pclk = 0;
   logic        presetn = 0;
   logic        psel = 0;
   logic        penable = 0;
   logic        pwrite = 0;
   logic [9:0]  paddr = 10'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [31:0] prdata, q, r;
   logic        pready, pslverr, e;
   logic [31:0] rxv = 32'h0;
   logic [7:0]  txv = 8'h0;
   logic        frame_sync = 0;
   logic [1:0]  pin_out, pin_oe_n, level;
   logic [11:0] cfg = 12'hfff;
   logic [7:0]  c0, c1;
   logic [31:0] seed = 32'h54;
   int          failures = 0;
   int          samples_checked = 0;
   int          cyc = 0;

   gosm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .rx_status(rxv), .tx_status(txv), .frame_sync, .pin_out, .pin_oe_n);
   gosm_board u_board (.pclk, .pin_out, .pin_oe_n, .level);

   always #4 pclk = ~pclk;
   // Hang guard: the whole run needs far fewer cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected pin data from a control byte and the live status
   function automatic logic exp_pin(input logic [7:0] c);
      int s, k;
      logic [3:0] m, lk, ps, en;
      s = c[4:2];
      k = c[7:5];
      en = cfg[11:8];
      m = (s == 6) ? cfg[7:4] : cfg[3:0];
      for (int i = 0; i < 4; i++) begin
         lk[i] = rxv[i*8+3];
         ps[i] = rxv[i*8+2];
      end
      if (s < 4) return rxv[s*8 + (k < 4 ? 4 + k : 7 - k)];
      if (s == 5) return 1'h0;
      if (s == 4) case (k)
         0: return c[1];
         1: return |(lk & en);
         2: return &(lk | ~en);
         3: return &(ps | ~en);
         4: return frame_sync;
         default: return 1'h0;
      endcase
      case (k)
         0: return &(ps | ~m);
         1: return |(ps & m);
         6, 7: return 1'h0;
         default: return txv[(s-6)*4 + 5 - k];
      endcase
   endfunction

   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Only the hang guard ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      check("oe_n", 32'h3, {30'h0, pin_oe_n});
      apb(0, 10'h040, 32'h0);
      check("pin0 ctl", 32'h0, q);
      apb(0, 10'h044, 32'h0);
      check("pin1 ctl", 32'h0, q);
      apb(0, 10'h0c0, 32'h0);
      check("unmapped", 32'h1, {31'h0, e});
      // Low strobe off must leave the byte alone
      pstrb <= 4'he;
      apb(1, 10'h044, 32'hff);
      pstrb <= 4'hf;
      apb(0, 10'h044, 32'h0);
      check("strobe", 32'h0, q);
      $display("register test done");
      for (int i = 0; i < 128; i++) begin
         if (i % 16 == 0) begin
            cfg = 12'(rnd());
            apb(1, 10'h080, {20'h0, cfg});
         end
         r = rnd();
         rxv <= r;
         r = rnd();
         txv <= r[7:0];
         frame_sync <= r[8];
         c0 = {i[5:0], r[9], 1'h1};
         c1 = r[23:16];
         apb(1, 10'h040, {24'h0, c0});
         apb(1, 10'h044, {24'h0, c1});
         apb(0, 10'h044, 32'h0);
         check("pin1 ctl", {24'h0, c1}, q);
         repeat (8) @(posedge pclk);
         check("pin0", exp_pin(c0), level[0]);
         check("pin1 oe_n", !c1[0], pin_oe_n[1]);
         if (c1[0])
            check("pin1", exp_pin(c1), level[1]);
         // Status word shows both drivers, enabled or not
         apb(0, 10'h084, 32'h0);
         check("pin status", {28'h0, !c1[0], 1'h0, exp_pin(c1), exp_pin(c0)}, q);
      end
      $display("source sweep done");
      wrap_up();
   end
endmodule
